// file: logic/swc_sleep_ctrl.sv
// Sleep entry, wake-up and status flag control with an AHB-Lite register slave
//
// Notes on behaviour
// - Sleep entered only by sleep instruction
// - Watchdog cleared at entry, keeps counting
// - Entry clears power-down flag, sets timeout flag
// - Main oscillator driver off during sleep
// - I/O drive states held during sleep
// - Watchdog reset never drives reset pin
// - Pin reset resets; others resume execution
// - Watchdog wake clears timeout flag
// - Power-down flag set at power-up
// - Listed peripheral sources may wake device
// - Clock-dependent peripherals give no sleep interrupts
// - Next instruction prefetched during sleep
// - Enabled source wakes, regardless of global enable
// - Global enable picks in-line or vector
// - Watchdog cleared on every wake-up
// - Pending enabled flag makes sleep no-op
// - Interrupt during sleep: complete, wake at once
// - Crystal modes wait oscillator start-up delay
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module swc_sleep_ctrl #(
   parameter int NSRC = 12,
   parameter int IO_W = 16,
   parameter int OSC_DIV = 4,
   parameter int OST_CYCLES = `SWC_OST_OSC_PERIODS * OSC_DIV
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Core side
   input wire swc_pkg::swc_core_req_t core_req,
   output var swc_pkg::swc_core_rsp_t core_rsp,
   output logic core_stall,
   // Interrupt sources, raw flags, gated inside by the per-source enable register
   input wire logic [NSRC-1:0] irq_flag,
   input wire logic [NSRC-1:0] src_sleep_ok,
   // Pins and watchdog
   input wire logic reset_pin_n,
   input wire logic wdt_timeout,
   output logic wdt_clear,
   output logic wdt_run,
   output logic osc_drv_en,
   output logic internal_rst,
   output logic io_freeze,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq
);
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST} st_t;
   st_t st_q;
   logic [1:0] rpin_sync_q;
   logic [1:0] wdt_sync_q;
   logic [NSRC-1:0] flg_s1_q, flg_s2_q;
   logic [31:0] ctrl_q;
   logic [NSRC-1:0] src_en_q;
   logic [2:0] irq_stat_q, irq_mask_q;
   logic pd_n_q, to_n_q;
   logic [15:0] ost_cnt_q;
   logic wr_pend_q;
   logic [7:0] addr_q;
   logic [NSRC-1:0] wake_vec;
   logic wake_req, wdt_wake, pin_rst;
   logic sleep_entry, sleep_nop, wake_now;
   // Synchronise pin and asynchronous source inputs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rpin_sync_q <= 2'h3;
         wdt_sync_q <= 2'h0;
         flg_s1_q <= '0;
         flg_s2_q <= '0;
      end else begin
         rpin_sync_q <= {rpin_sync_q[0], reset_pin_n};
         wdt_sync_q <= {wdt_sync_q[0], wdt_timeout};
         flg_s1_q <= irq_flag;
         flg_s2_q <= flg_s1_q;
      end
   end
   // Per-source wake qualification; only sleep-capable sources count
   generate
      for (genvar i = 0; i < NSRC; i++) begin : g_src
         assign wake_vec[i] = flg_s2_q[i] & src_en_q[i] & src_sleep_ok[i];
      end
   endgenerate
   assign wake_req = |wake_vec;
   assign pin_rst = ~rpin_sync_q[1];
   assign wdt_wake = wdt_sync_q[1] & ctrl_q[`SWC_CTRL_WDT_EN];
   assign sleep_entry = (st_q == ST_RUN) && core_req.sleep_exec && !wake_req;
   assign sleep_nop = (st_q == ST_RUN) && core_req.sleep_exec && wake_req;
   assign wake_now = (st_q == ST_SLEEP) && (wake_req || wdt_wake);
   // Sleep sequencer
   always_ff @(posedge clk_sys) begin
      if (sys_rst || pin_rst) begin
         st_q <= ST_RUN;
         ost_cnt_q <= 16'h0000;
      end else begin
         case (st_q)
            ST_RUN: begin
               if (sleep_entry) st_q <= ST_SLEEP;
            end
            ST_SLEEP: begin
               if (wake_now) begin
                  if (ctrl_q[`SWC_CTRL_XTAL]) begin
                     st_q <= ST_OST;
                     ost_cnt_q <= 16'(OST_CYCLES - 1);
                  end else begin
                     st_q <= ST_RUN;
                  end
               end
            end
            ST_OST: begin
               if (ost_cnt_q == 16'h0000) st_q <= ST_RUN;
               else ost_cnt_q <= ost_cnt_q - 16'h0001;
            end
            default: st_q <= ST_RUN;
         endcase
      end
   end
   // Core resume handshake holding the prefetched address
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         core_rsp <= '0;
         core_stall <= 1'b0;
      end else begin
         core_rsp.resume <= 1'b0;
         core_rsp.take_vector <= 1'b0;
         if (sleep_entry) begin
            core_rsp.resume_pc <= core_req.next_pc;
            core_stall <= 1'b1;
         end
         if (pin_rst) begin
            core_stall <= 1'b0;
         end else if ((st_q == ST_SLEEP && wake_now && !ctrl_q[`SWC_CTRL_XTAL]) ||
                      (st_q == ST_OST && ost_cnt_q == 16'h0000)) begin
            core_stall <= 1'b0;
            core_rsp.resume <= 1'b1;
            core_rsp.take_vector <= ctrl_q[`SWC_CTRL_GIE];
         end
      end
   end
   // Watchdog, oscillator and I/O hold controls
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wdt_clear <= 1'b0;
         wdt_run <= 1'b0;
         osc_drv_en <= 1'b1;
         io_freeze <= 1'b0;
         internal_rst <= 1'b0;
      end else begin
         wdt_clear <= sleep_entry || wake_now;
         wdt_run <= ctrl_q[`SWC_CTRL_WDT_EN] && st_q != ST_OST;
         osc_drv_en <= !(sleep_entry || (st_q == ST_SLEEP && !wake_now));
         io_freeze <= sleep_entry || (st_q == ST_SLEEP);
         // Watchdog time-out while awake resets inside only
         internal_rst <= pin_rst || (wdt_sync_q[1] && ctrl_q[`SWC_CTRL_WDT_EN]
                          && st_q == ST_RUN);
      end
   end
   // Status flags, active low
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pd_n_q <= 1'b1;
         to_n_q <= 1'b1;
      end else if (sleep_entry) begin
         pd_n_q <= 1'b0;
         to_n_q <= 1'b1;
      end else if (st_q == ST_SLEEP && !wake_req && wdt_wake) begin
         to_n_q <= 1'b0;
      end
   end
   // AHB-Lite address phase capture; zero wait states
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= hsel && htrans[1] && hwrite;
         addr_q <= haddr;
      end
   end
   // Control and enable registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q <= `SWC_CTRL_RST;
         src_en_q <= NSRC'(`SWC_SRC_EN_RST);
         irq_mask_q <= 3'h0;
      end else if (wr_pend_q) begin
         case (addr_q)
            `SWC_OFF_CTRL: ctrl_q <= {29'h0, hwdata[2:0]};
            `SWC_OFF_IRQ_MASK: irq_mask_q <= hwdata[2:0];
            `SWC_OFF_SRC_EN: src_en_q <= hwdata[NSRC-1:0];
            default: ;
         endcase
      end
   end
   // Sticky event status; a new event wins over write-one-to-clear
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_stat_q <= 3'h0;
      end else begin
         logic [2:0] clr, set;
         clr = (wr_pend_q && addr_q == `SWC_OFF_IRQ_STAT) ? hwdata[2:0] : 3'h0;
         set = {sleep_nop, wdt_wake && st_q == ST_SLEEP, wake_now};
         irq_stat_q <= (irq_stat_q & ~clr) | set;
      end
   end
   // Read data, sampled at address phase so it stands in the data phase
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
         if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr)
               `SWC_OFF_CTRL: hrdata <= ctrl_q;
               `SWC_OFF_STAT: hrdata <= {29'h0, st_q == ST_SLEEP, to_n_q, pd_n_q};
               `SWC_OFF_IRQ_STAT: hrdata <= {29'h0, irq_stat_q};
               `SWC_OFF_IRQ_MASK: hrdata <= {29'h0, irq_mask_q};
               `SWC_OFF_SRC_EN: hrdata <= {{(32-NSRC){1'b0}}, src_en_q};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Helper: cycles spent in the start-up wait, so its length can be checked
   logic [15:0] ost_seen_q;
   always_ff @(posedge clk_sys) begin
      if (sys_rst || pin_rst) begin
         ost_seen_q <= 16'h0000;
      end else if (st_q == ST_OST) begin
         ost_seen_q <= ost_seen_q + 16'h0001;
      end else begin
         ost_seen_q <= 16'h0000;
      end
   end

   // Checks
   // Only the instruction may put the block to sleep
   a_sleep_only_instr: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_RUN && !core_req.sleep_exec) |=> st_q != ST_SLEEP)
      else $error("sleep without instruction");

   // Core held while asleep
   a_stall_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst || pin_rst)
      (st_q == ST_SLEEP && !wake_now) |=> core_stall)
      else $error("core not stalled in sleep");

   // Power-down flag clears, timeout flag sets and watchdog clears on entry
   a_entry_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sleep_entry |=> (!pd_n_q && to_n_q && wdt_clear))
      else $error("entry flags wrong");

   // Watchdog keeps counting in sleep
   a_wdt_run_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_SLEEP && ctrl_q[`SWC_CTRL_WDT_EN]) |=> wdt_run)
      else $error("watchdog stopped in sleep");

   // Watchdog held while the start-up count uses it
   a_ost_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_OST) |=> !wdt_run)
      else $error("watchdog running in start-up wait");

   // Oscillator driver off in sleep
   a_osc_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_SLEEP && !wake_now) |=> !osc_drv_en)
      else $error("oscillator on in sleep");

   // And back on while running
   a_osc_on_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_RUN && !sleep_entry) |=> osc_drv_en)
      else $error("oscillator off while running");

   // Pins frozen in sleep
   a_io_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_SLEEP) |=> io_freeze)
      else $error("io not held");

   // Pins released while running
   a_io_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_RUN && !sleep_entry) |=> !io_freeze)
      else $error("io held while running");

   // Awake watchdog time-out resets inside only
   a_internal_wdt: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (wdt_sync_q[1] && ctrl_q[`SWC_CTRL_WDT_EN] && st_q == ST_RUN) |=> internal_rst)
      else $error("watchdog reset missing");

   // Pin reset restarts without a resume
   a_pin_reset_seq: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pin_rst |=> (st_q == ST_RUN && internal_rst && !core_rsp.resume))
      else $error("pin reset not applied");

   // Resume always frees the core
   a_resume_unstall: assert property (@(posedge clk_sys) disable iff (sys_rst)
      core_rsp.resume |-> !core_stall)
      else $error("resume while stalled");

   // Watchdog wake marks the timeout flag
   a_wdt_to_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_SLEEP && wdt_wake && !wake_req) |=> !to_n_q)
      else $error("timeout flag not cleared");

   // Power-down flag falls only on entry
   a_pd_powerup: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (pd_n_q && !sleep_entry) |=> pd_n_q)
      else $error("power-down flag cleared without sleep");

   // Prefetched address kept for resume
   a_entry_pc: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sleep_entry |=> core_rsp.resume_pc == $past(core_req.next_pc))
      else $error("prefetch address lost");

   // No enabled source, no wake
   a_no_wake_idle: assert property (@(posedge clk_sys) disable iff (sys_rst || pin_rst)
      (st_q == ST_SLEEP && !wake_now) |=> st_q == ST_SLEEP)
      else $error("woke without a source");

   // Vector only with a resume
   a_vector_resume: assert property (@(posedge clk_sys) disable iff (sys_rst)
      core_rsp.take_vector |-> core_rsp.resume)
      else $error("vector without resume");

   // Vector follows the global enable
   a_vector_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
      core_rsp.resume |-> core_rsp.take_vector == $past(ctrl_q[`SWC_CTRL_GIE]))
      else $error("vector choice wrong");

   // Every wake clears the watchdog
   a_wake_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wake_now |=> wdt_clear)
      else $error("wake without watchdog clear");

   // Pending source turns sleep into a no-op
   a_nop_no_change: assert property (@(posedge clk_sys) disable iff (sys_rst || pin_rst)
      sleep_nop |=> ($stable(pd_n_q) && !wdt_clear && st_q == ST_RUN))
      else $error("nop sleep changed state");

   // No-op is recorded for software
   a_nop_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sleep_nop |=> irq_stat_q[2])
      else $error("no-op not recorded");

   // Interrupt wake keeps the timeout flag
   a_to_irq_wake: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_SLEEP && wake_req) |=> $stable(to_n_q))
      else $error("timeout flag moved on interrupt wake");

   // Power-down flag stays clear through sleep
   a_pd_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ST_SLEEP) |=> !pd_n_q)
      else $error("power-down flag set in sleep");

   // Wake is recorded for software
   a_wake_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wake_now |=> irq_stat_q[0])
      else $error("wake not recorded");

   // No early resume in crystal mode
   a_ost_wait: assert property (@(posedge clk_sys) disable iff (sys_rst || pin_rst)
      (st_q == ST_SLEEP && wake_now && ctrl_q[`SWC_CTRL_XTAL]) |=> !core_rsp.resume [*8])
      else $error("resumed before start-up delay");

   // Start-up wait lasts the full count
   a_ost_length: assert property (@(posedge clk_sys) disable iff (sys_rst || pin_rst)
      (st_q == ST_OST && ost_cnt_q == 16'h0000) |-> ost_seen_q == 16'(OST_CYCLES - 1))
      else $error("start-up wait length wrong");

   c_sleep: cover property (@(posedge clk_sys) sleep_entry);
   c_irq_wake: cover property (@(posedge clk_sys) wake_now && wake_req);
   c_wdt_wake: cover property (@(posedge clk_sys) wake_now && !wake_req);
   c_nop: cover property (@(posedge clk_sys) sleep_nop);
   c_xtal_resume: cover property (@(posedge clk_sys) st_q == ST_OST && ost_cnt_q == 16'h0000);
endmodule // swc_sleep_ctrl
`default_nettype wire

// file: shared/swc_map.svh
// Register offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_OFF_CTRL 8'h00
`define SWC_OFF_STAT 8'h04
`define SWC_OFF_IRQ_STAT 8'h08
`define SWC_OFF_IRQ_MASK 8'h0c
`define SWC_OFF_SRC_EN 8'h10
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_XTAL 1
`define SWC_CTRL_GIE 2
`define SWC_STAT_PD 0
`define SWC_STAT_TO 1
`define SWC_STAT_ASLEEP 2
`define SWC_CTRL_RST 32'h0000_0000
`define SWC_SRC_EN_RST 12'h000
`define SWC_OST_OSC_PERIODS 1024
`define SWC_IRQ_VECTOR 13'h0004
`endif

// file: shared/swc_pkg.sv
// Types shared by the sleep and wake-up controller
package swc_pkg;
   typedef enum logic [1:0] {
      SWC_WAKE_NONE,
      SWC_WAKE_WDT,
      SWC_WAKE_IRQ
   } swc_wake_t;
   typedef struct packed {
      logic sleep_exec;
      logic [12:0] next_pc;
   } swc_core_req_t;
   typedef struct packed {
      logic resume;
      logic take_vector;
      logic [12:0] resume_pc;
   } swc_core_rsp_t;
endpackage

// file: tb/swc_core_model.sv
// Core model that issues the sleep instruction and records the controller's answers
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Bench control
   input wire logic go,
   input wire logic [12:0] pc,
   // Controller side
   output var swc_pkg::swc_core_req_t core_req,
   input wire swc_pkg::swc_core_rsp_t core_rsp,
   input wire logic wdt_clear,
   input wire logic internal_rst,
   // Observations
   output logic [7:0] resumes,
   output logic [7:0] clears,
   output logic vec_q,
   output logic [12:0] pc_q,
   output logic rst_seen
);
   // One-cycle sleep pulse; the next address stands while asleep
   always_ff @(posedge clk_sys) begin
      core_req.sleep_exec <= go & ~sys_rst;
      core_req.next_pc <= 13'(pc + 13'h0001);
   end
   // Record resumes, watchdog clears and internal resets
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         resumes <= 8'h00;
         clears <= 8'h00;
         vec_q <= 1'b0;
         pc_q <= 13'h0000;
         rst_seen <= 1'b0;
      end else begin
         if (core_rsp.resume) begin
            resumes <= resumes + 8'h01;
            vec_q <= core_rsp.take_vector;
            pc_q <= core_rsp.resume_pc;
         end
         clears <= clears + {7'h00, wdt_clear};
         rst_seen <= rst_seen | internal_rst;
      end
   end
endmodule // swc_core_model
`default_nettype wire

// file: tb/swc_sleep_ctrl_tb.sv
// Self-checking bench of the sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module swc_sleep_ctrl_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic go = 1'b0;
   logic [12:0] pc = 13'h0000;
   logic [11:0] irq_flag = 12'h000;
   logic [11:0] src_sleep_ok = 12'hfff;
   logic reset_pin_n = 1'b1;
   logic wdt_timeout = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd, s;
   logic hready, hreadyout, hresp, irq, core_stall, wdt_clear, wdt_run;
   logic osc_drv_en, internal_rst, io_freeze, vec, rst_seen;
   logic [7:0] res, clr, r0, c0;
   logic [12:0] pc_q;
   swc_pkg::swc_core_req_t core_req;
   swc_pkg::swc_core_rsp_t core_rsp;
   int fails = 0;
   int samples_checked = 0;
   int seed = 38;
   int n;
   always #4 clk_sys = ~clk_sys;
   assign hready = hreadyout;
   // Short start-up delay keeps the crystal case quick
   swc_sleep_ctrl #(.OST_CYCLES(16)) u_dut (.clk_sys, .sys_rst, .core_req, .core_rsp,
      .core_stall, .irq_flag, .src_sleep_ok, .reset_pin_n, .wdt_timeout, .wdt_clear, .wdt_run,
      .osc_drv_en, .internal_rst, .io_freeze, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq);
   swc_core_model u_core (.clk_sys, .sys_rst, .go, .pc, .core_req, .core_rsp, .wdt_clear,
      .internal_rst, .resumes(res), .clears(clr), .vec_q(vec), .pc_q, .rst_seen);
   // Resume address expected after a sleep at p
   function automatic logic [12:0] exp_pc(input logic [12:0] p);
      return p + 13'h0001;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait for hready at a rising edge
   task automatic tick_ready();
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         wrap_up();
      end
   endtask
   // One single-word transfer; read data taken at the closing edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      tick_ready();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      tick_ready();
      rd = hrdata;
   endtask
   task automatic wait_res(input int lim);
      n = 0;
      while (res === r0 && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      #1;
   endtask
   // Sleep from a random address, then let entry settle
   task automatic snooze(input logic [31:0] ctrl);
      ahb(1'b1, `SWC_OFF_CTRL, ctrl);
      pc <= 13'($random(seed));
      r0 = res;
      c0 = clr;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic quiet();
      irq_flag <= 12'h000;
      src_sleep_ok <= 12'hfff;
      repeat (4) @(posedge clk_sys);
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("osc_drv_en", 1, osc_drv_en);
      ahb(1'b0, `SWC_OFF_STAT, 0);
      chk("stat", 3, rd);
      ahb(1'b1, `SWC_OFF_SRC_EN, 32'hfff);
      ahb(1'b1, `SWC_OFF_IRQ_MASK, 32'h7);
      $display("test reset done");
      // Interrupt wake, in-line then vectored
      for (int g = 0; g < 2; g++) begin
         snooze({29'h0, g[0], 2'b01});
         chk("core_stall", 1, core_stall);
         chk("osc_drv_en", 0, osc_drv_en);
         chk("io_freeze", 1, io_freeze);
         chk("wdt_run", 1, wdt_run);
         ahb(1'b0, `SWC_OFF_STAT, 0);
         chk("stat", 6, rd);
         irq_flag <= 12'h001 << ($unsigned($random(seed)) % 12);
         wait_res(10);
         chk("resumed", 1, res !== r0);
         chk("vector", g, vec);
         chk("resume_pc", exp_pc(pc), pc_q);
         chk("clears", 2, clr - c0);
         quiet();
      end
      $display("test interrupt wake done");
      // Pending enabled flag turns sleep into a no-op
      irq_flag <= 12'h008;
      repeat (4) @(posedge clk_sys);
      ahb(1'b0, `SWC_OFF_STAT, 0);
      s = rd;
      snooze(32'h1);
      chk("core_stall", 0, core_stall);
      chk("clears", 0, clr - c0);
      ahb(1'b0, `SWC_OFF_STAT, 0);
      chk("stat", s, rd);
      quiet();
      ahb(1'b0, `SWC_OFF_IRQ_STAT, 0);
      chk("noop_bit", 1, rd[2]);
      chk("irq", 1, irq);
      ahb(1'b1, `SWC_OFF_IRQ_STAT, 32'h7);
      ahb(1'b0, `SWC_OFF_IRQ_STAT, 0);
      chk("irq_stat", 0, rd);
      chk("irq", 0, irq);
      $display("test no-op done");
      // Disabled or clock-bound sources stay asleep; watchdog wakes
      for (int k = 0; k < 2; k++) begin
         ahb(1'b1, `SWC_OFF_SRC_EN, k ? 32'hfff : 32'h0);
         src_sleep_ok <= k ? 12'h000 : 12'hfff;
         snooze(32'h1);
         irq_flag <= 12'h010;
         wait_res(20);
         chk("resumed", 0, res !== r0);
         wdt_timeout <= 1'b1;
         @(posedge clk_sys);
         wdt_timeout <= 1'b0;
         wait_res(10);
         chk("resumed", 1, res !== r0);
         ahb(1'b0, `SWC_OFF_STAT, 0);
         chk("stat", 0, rd);
         quiet();
      end
      chk("internal_rst", 0, rst_seen);
      $display("test watchdog wake done");
      // Crystal mode waits for oscillator start-up
      snooze(32'h3);
      irq_flag <= 12'h800;
      wait_res(200);
      chk("ost_wait", 1, n > 16);
      chk("resumed", 1, res !== r0);
      quiet();
      $display("test crystal done");
      // Pin reset during sleep resets the sequencer
      snooze(32'h1);
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("internal_rst", 1, rst_seen);
      chk("core_stall", 0, core_stall);
      $display("test pin reset done");
      wrap_up();
   end
endmodule // swc_sleep_ctrl_tb
`default_nettype wire
